/* core/host_port_pkg.sv */
// shared constants and types for the parallel host port bus control
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int PIN_W = 4;
    localparam int BUF_DEPTH = 2;
    // general-purpose line number carried by control pin index 0
    localparam int GPIO_LINE_FIRST = 11;
    // control pin indices, in general-purpose line order 11..14
    localparam int PIN_DIR_SEL = 0;
    localparam int PIN_STROBE = 1;
    localparam int PIN_REQUEST = 2;
    localparam int PIN_ACK = 3;
    localparam logic STROBE_ACTIVE = 1'h0;
    localparam logic ACK_ACTIVE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic REQ_PULL_LEVEL = 1'h0;
    // pulled-up idle level of the control pins, used as synchroniser reset
    localparam logic [PIN_W-1:0] PIN_IDLE = 4'hF;
    localparam logic [PIN_W-1:0] PIN_OE_RESET = 4'h0;
    localparam logic [PIN_W-1:0] PIN_OUT_RESET = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'h0,
        ACC_READ = 2'h1,
        ACC_WRITE = 2'h3,
        ACC_ACK = 2'h2
    } access_state_e;
endpackage

/* core/pin_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* core/word_buffer.sv */
// small shifting word buffer with valid/ready on both sides
`timescale 1ns/1ns
module word_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;

    assign out_data_o = mem_q[0];
    assign pop = out_valid_o && out_ready_i;
    // a pop in the same cycle frees the slot, so a full buffer still accepts
    assign in_ready_o = (count_q != CW'(DEPTH)) || pop;
    assign push = in_valid_i && in_ready_o;
    assign count_d = count_q + CW'(push) - CW'(pop);

    // valid kept in its own flop so the consumer sees a registered flag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_q <= '0;
            out_valid_o <= 1'h0;
        end
        else
        begin
            count_q <= count_d;
            out_valid_o <= (count_d != '0);
        end
    end

    for (genvar i = 0; i < DEPTH; i++)
    begin : g_entry
        logic [WIDTH-1:0] above;
        if (i < DEPTH - 1)
        begin : g_mid
            assign above = mem_q[i+1];
        end
        else
        begin : g_top
            assign above = '0;
        end
        always_ff @(posedge clk_i or negedge rst_n_i)
        begin
            if (!rst_n_i)
                mem_q[i] <= '0;
            else if (pop)
                mem_q[i] <= (push && count_q == CW'(i + 1)) ? in_data_i : above;
            else if (push && count_q == CW'(i))
                mem_q[i] <= in_data_i;
        end
    end
endmodule

/* core/host_port_bus_control.sv */
// bus control of the 8-bit parallel host port with general-purpose fallback
`timescale 1ns/1ns
module host_port_bus_control #(
    parameter int DATA_W = host_port_pkg::DATA_W,
    parameter int BUF_DEPTH = host_port_pkg::BUF_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic host_port_sel_i,
    input wire logic [host_port_pkg::PIN_W-1:0] ctl_pin_i,
    output logic [host_port_pkg::PIN_W-1:0] ctl_pin_o,
    output logic [host_port_pkg::PIN_W-1:0] ctl_pin_oe_o,
    input wire logic [DATA_W-1:0] host_data_lines_i,
    output logic [DATA_W-1:0] host_data_lines_o,
    output logic host_data_lines_oe_o,
    input wire logic svc_req_i,
    input wire logic ack_dma_mode_i,
    input wire logic [DATA_W-1:0] rd_data_i,
    output logic rd_done_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [DATA_W-1:0] wr_data_o,
    output logic dma_ack_o,
    output logic int_ack_o,
    input wire logic [host_port_pkg::PIN_W-1:0] gpio_dir_i,
    input wire logic [host_port_pkg::PIN_W-1:0] gpio_out_i,
    output logic [host_port_pkg::PIN_W-1:0] gpio_in_o
);
    localparam int PW = host_port_pkg::PIN_W;

    logic [PW-1:0] pin_s;
    logic [DATA_W-1:0] data_s;
    logic [DATA_W-1:0] data_prev_q;
    logic strobe_act;
    logic ack_act;
    logic dir_read;
    logic req_q;
    logic buf_ready;
    logic push;
    host_port_pkg::access_state_e state_q;
    host_port_pkg::access_state_e state_d;

    pin_sync #(
        .WIDTH(PW),
        .RST_VAL(host_port_pkg::PIN_IDLE)
    ) u_pin_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(ctl_pin_i),
        .q_o(pin_s)
    );

    pin_sync #(
        .WIDTH(DATA_W),
        .RST_VAL(DATA_W'(host_port_pkg::DATA_RESET))
    ) u_data_sync (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .d_i(host_data_lines_i),
        .q_o(data_s)
    );

    assign strobe_act = (pin_s[host_port_pkg::PIN_STROBE] == host_port_pkg::STROBE_ACTIVE);
    assign ack_act = (pin_s[host_port_pkg::PIN_ACK] == host_port_pkg::ACK_ACTIVE);
    assign dir_read = (pin_s[host_port_pkg::PIN_DIR_SEL] == host_port_pkg::DIR_READ);

    // direction is sampled at strobe entry only; host keeps it steady
    // strobe outranks a pending acknowledge so a host access is never lost
    always_comb
    begin
        state_d = host_port_pkg::ACC_IDLE;
        case (state_q)
            host_port_pkg::ACC_IDLE,
            host_port_pkg::ACC_ACK:
            begin
                if (!host_port_sel_i)
                    state_d = host_port_pkg::ACC_IDLE;
                else if (strobe_act)
                    state_d = dir_read ? host_port_pkg::ACC_READ : host_port_pkg::ACC_WRITE;
                else if (ack_act && req_q)
                    state_d = host_port_pkg::ACC_ACK;
            end
            host_port_pkg::ACC_READ,
            host_port_pkg::ACC_WRITE:
            begin
                if (host_port_sel_i && strobe_act)
                    state_d = state_q;
            end
            default: state_d = host_port_pkg::ACC_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= host_port_pkg::ACC_IDLE;
        else
            state_q <= state_d;
    end

    // data lines driven only for a read or an acknowledged request
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            host_data_lines_oe_o <= 1'h0;
        else
            host_data_lines_oe_o <= (state_d == host_port_pkg::ACC_READ)
                || (state_d == host_port_pkg::ACC_ACK);
    end

    // output word frozen while driven so the host sees stable data
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            host_data_lines_o <= DATA_W'(host_port_pkg::DATA_RESET);
        else if (state_q == host_port_pkg::ACC_IDLE)
            host_data_lines_o <= rd_data_i;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rd_done_o <= 1'h0;
        else
            rd_done_o <= (state_q == host_port_pkg::ACC_READ)
                && (state_d != host_port_pkg::ACC_READ);
    end

    // last sample taken while the strobe was still low
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            data_prev_q <= DATA_W'(host_port_pkg::DATA_RESET);
        else
            data_prev_q <= data_s;
    end

    // capture at the strobe's rising edge, input only during writes
    assign push = (state_q == host_port_pkg::ACC_WRITE) && !strobe_act;

    word_buffer #(
        .WIDTH(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_wr_buf (
        .clk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_ready_o(buf_ready),
        .in_data_i(data_prev_q),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_data_o)
    );

    // acknowledge role chosen by mode: DMA handshake or interrupt cycle
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dma_ack_o <= 1'h0;
            int_ack_o <= 1'h0;
        end
        else
        begin
            dma_ack_o <= (state_q != host_port_pkg::ACC_ACK)
                && (state_d == host_port_pkg::ACC_ACK) && ack_dma_mode_i;
            int_ack_o <= (state_q != host_port_pkg::ACC_ACK)
                && (state_d == host_port_pkg::ACC_ACK) && !ack_dma_mode_i;
        end
    end

    // request withheld while the write buffer is full and not popped that cycle, so the host holds off
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            req_q <= 1'h0;
        else
            req_q <= svc_req_i && buf_ready;
    end

    // pin function select; all pins undriven under reset
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctl_pin_oe_o <= host_port_pkg::PIN_OE_RESET;
            ctl_pin_o <= host_port_pkg::PIN_OUT_RESET;
        end
        else if (host_port_sel_i)
        begin
            // open drain: only ever pulls low, pull-up gives idle high
            ctl_pin_oe_o <= PW'(req_q) << host_port_pkg::PIN_REQUEST;
            ctl_pin_o <= {PW{host_port_pkg::REQ_PULL_LEVEL}};
        end
        else
        begin
            // plain push-pull general-purpose drive, line 13 included
            ctl_pin_oe_o <= gpio_dir_i;
            ctl_pin_o <= gpio_out_i;
        end
    end

    assign gpio_in_o = pin_s;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_read_access;
        host_port_sel_i && strobe_act && dir_read && state_q == host_port_pkg::ACC_IDLE;
    endsequence

    sequence s_write_end;
        state_q == host_port_pkg::ACC_WRITE && !strobe_act && buf_ready;
    endsequence

    chk_read_drive: assert property (s_read_access |=> host_data_lines_oe_o [*2])
        else $error("data lines not driven during read");

    chk_write_input: assert property (
        state_q == host_port_pkg::ACC_WRITE |-> !host_data_lines_oe_o)
        else $error("data lines driven during write");

    chk_write_capture: assert property (
        s_write_end |=> wr_valid_o)
        else $error("write word not pushed at strobe rise");

    chk_capture_data: assert property (
        s_write_end ##0 !wr_valid_o |=> wr_valid_o && wr_data_o == $past(data_prev_q))
        else $error("written word not captured at strobe rise");

    chk_idle_release: assert property (
        host_port_sel_i && !strobe_act && !(ack_act && req_q) |=> !host_data_lines_oe_o)
        else $error("data lines driven with strobe inactive");

    chk_ack_drive: assert property (
        host_port_sel_i && ack_act && req_q && state_q == host_port_pkg::ACC_IDLE
        && !strobe_act |=> host_data_lines_oe_o && (dma_ack_o || int_ack_o))
        else $error("acknowledge during request did not drive data");

    chk_dma_role: assert property (
        dma_ack_o |-> !int_ack_o && $past(ack_dma_mode_i))
        else $error("dma acknowledge in wrong mode");

    chk_int_role: assert property (
        int_ack_o |-> $past(!ack_dma_mode_i) && state_q == host_port_pkg::ACC_ACK)
        else $error("interrupt acknowledge in wrong mode");

    chk_req_open_drain: assert property (
        host_port_sel_i |=> ctl_pin_o == '0 && ctl_pin_oe_o[host_port_pkg::PIN_REQUEST]
        == $past(req_q) && ctl_pin_oe_o[host_port_pkg::PIN_STROBE] == 1'h0)
        else $error("request pin not open drain in host mode");

    chk_gpio_push_pull: assert property (
        !host_port_sel_i |=> ctl_pin_oe_o == $past(gpio_dir_i)
        && ctl_pin_o == $past(gpio_out_i))
        else $error("general-purpose drive mismatch");

    chk_read_frozen: assert property (
        state_q == host_port_pkg::ACC_READ && $past(state_q) == host_port_pkg::ACC_READ
        |-> $stable(host_data_lines_o))
        else $error("read word changed during access");

    chk_rd_done_release: assert property (
        rd_done_o |-> !host_data_lines_oe_o)
        else $error("data lines still driven at read end");

    chk_ack_pulse: assert property (
        dma_ack_o || int_ack_o |=> !dma_ack_o && !int_ack_o)
        else $error("acknowledge pulse longer than one cycle");

    chk_gpio_release: assert property (
        !host_port_sel_i |=> !host_data_lines_oe_o)
        else $error("data lines driven in general-purpose mode");

    chk_req_gated: assert property (
        !buf_ready ##1 host_port_sel_i |=> !ctl_pin_oe_o[host_port_pkg::PIN_REQUEST])
        else $error("request pulled while write buffer full");

    chk_pull_level: assert property (
        ctl_pin_oe_o[host_port_pkg::PIN_REQUEST] && $past(host_port_sel_i)
        |-> !ctl_pin_o[host_port_pkg::PIN_REQUEST])
        else $error("request pin driven high in host mode");

    chk_reset_inputs: assert property (disable iff (1'h0)
        !rst_n_i |-> ctl_pin_oe_o == '0 && !host_data_lines_oe_o)
        else $error("pin driven during reset");
endmodule

/* verif/host_model.sv */
// host processor model facing the parallel host port pins
`timescale 1ns/1ns
module host_model (
    input wire logic mclk_i,
    input wire logic [3:0] ctl_pin_o,
    input wire logic [3:0] ctl_pin_oe_o,
    input wire logic [7:0] host_data_lines_o,
    input wire logic host_data_lines_oe_o,
    output logic [3:0] pin_lvl_o,
    output logic [7:0] data_lvl_o
);
    logic cs_q = 1'h0;
    logic en_q = 1'h0;
    logic dir_q = 1'h0;
    logic ack_n_q = 1'h1;
    logic data_en_q = 1'h0;
    logic [7:0] data_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [3:0] gp_en_q = 4'h0;
    logic [3:0] gp_val_q = 4'h0;
    logic [3:0] host_lvl;
    // strobe low only while chip select and enable are both active
    // request pin idles high through its pull-up
    always_comb
    begin
        host_lvl = {ack_n_q, 1'h1, ~(cs_q & en_q), dir_q};
        for (int i = 0; i < 4; i++)
            pin_lvl_o[i] = ctl_pin_oe_o[i] ? ctl_pin_o[i] : (gp_en_q[i] ? gp_val_q[i] : host_lvl[i]);
    end
    // undriven data lines show the inverse of the last driven level, not a stale copy
    assign data_lvl_o = host_data_lines_oe_o ? host_data_lines_o : (data_en_q ? data_q : ~last_q);
    always @(posedge mclk_i)
        if (host_data_lines_oe_o === 1'h1 || data_en_q)
            last_q <= data_lvl_o;
    task start(input logic dir, input logic [7:0] d);
        @(posedge mclk_i);
        dir_q <= dir;
        data_q <= d;
        data_en_q <= ~dir;
        cs_q <= 1'h1;
        en_q <= 1'h1;
    endtask
    // direction is left alone until the strobe is gone; data held one clock past it
    task stop();
        @(posedge mclk_i);
        cs_q <= 1'h0;
        en_q <= 1'h0;
        @(posedge mclk_i);
        data_en_q <= 1'h0;
    endtask
    // acknowledge driven as dma handshake or interrupt acknowledge
    task set_ack(input logic v);
        @(posedge mclk_i);
        ack_n_q <= v;
    endtask
    task drive_pins(input logic [3:0] en, input logic [3:0] v);
        @(posedge mclk_i);
        gp_en_q <= en;
        gp_val_q <= v;
    endtask
endmodule

/* verif/host_port_bus_control_tb_top.sv */
// self-checking testbench for the host port bus control
`timescale 1ns/1ns
module host_port_bus_control_tb_top;
    logic mclk_i = 1'h0;
    logic rst_n_i = 1'h1;
    logic host_port_sel_i = 1'h1;
    logic svc_req_i = 1'h0;
    logic ack_dma_mode_i = 1'h1;
    logic wr_ready_i = 1'h0;
    logic [7:0] rd_data_i = 8'h00;
    logic [3:0] gpio_dir_i = 4'h0;
    logic [3:0] gpio_out_i = 4'h0;
    logic [3:0] pin_lvl, ctl_pin_o, ctl_pin_oe_o, gpio_in_o;
    logic [7:0] data_lvl, host_data_lines_o, wr_data_o;
    logic host_data_lines_oe_o, rd_done_o, wr_valid_o, dma_ack_o, int_ack_o;
    int err_count = 0;
    int checks_done = 0;
    always #25 mclk_i = ~mclk_i;

    host_port_bus_control host_port_bus_control_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .host_port_sel_i(host_port_sel_i), .ctl_pin_i(pin_lvl), .ctl_pin_o(ctl_pin_o),
        .ctl_pin_oe_o(ctl_pin_oe_o), .host_data_lines_i(data_lvl),
        .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_o(host_data_lines_oe_o),
        .svc_req_i(svc_req_i), .ack_dma_mode_i(ack_dma_mode_i), .rd_data_i(rd_data_i),
        .rd_done_o(rd_done_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
        .wr_data_o(wr_data_o), .dma_ack_o(dma_ack_o), .int_ack_o(int_ack_o),
        .gpio_dir_i(gpio_dir_i), .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o));
    host_model host_model_i (.mclk_i(mclk_i), .ctl_pin_o(ctl_pin_o), .ctl_pin_oe_o(ctl_pin_oe_o),
        .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_o(host_data_lines_oe_o),
        .pin_lvl_o(pin_lvl), .data_lvl_o(data_lvl));

    task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // bounded wait for a given word at the head of the write buffer
    task wait_wr(input logic [7:0] d);
        int i;
        for (i = 0; i < 20 && !(wr_valid_o === 1'h1 && wr_data_o === d); i++)
            tick(1);
        check(wr_data_o, d, "write word");
        if (i == 20)
        begin
            err_count++;
            close_out();
        end
    endtask

    task test_reset();
        rst_n_i <= 1'h0;
        tick(5);
        check({4'h0, ctl_pin_oe_o}, 8'h00, "pin enables in reset");
        check({7'h00, host_data_lines_oe_o}, 8'h00, "data enable in reset");
        tick(4);
        @(posedge mclk_i);
        rst_n_i <= 1'h1;
        tick(3);
        check({4'h0, gpio_in_o}, 8'h0E, "lines read as inputs after reset");
        check({4'h0, ctl_pin_oe_o}, 8'h00, "no pin driven after reset");
        $display("test reset done");
    endtask
    task test_read();
        @(posedge mclk_i);
        rd_data_i <= 8'hA5;
        host_model_i.start(1'h1, 8'h00);
        tick(2);
        check({7'h00, host_data_lines_oe_o}, 8'h00, "released before strobe seen");
        tick(1);
        check({7'h00, host_data_lines_oe_o}, 8'h01, "read drives lines");
        check(data_lvl, 8'hA5, "read word");
        rd_data_i <= 8'h5A;
        tick(2);
        check(data_lvl, 8'hA5, "read word frozen");
        host_model_i.stop();
        tick(2);
        check({6'h00, rd_done_o, host_data_lines_oe_o}, 8'h02, "read end");
        $display("test read done");
    endtask
    // two writes fill the buffer while the consumer stalls, then drain
    task test_write();
        svc_req_i <= 1'h1;
        host_model_i.start(1'h0, 8'h3C);
        tick(4);
        check({7'h00, host_data_lines_oe_o}, 8'h00, "write keeps lines input");
        host_model_i.stop();
        wait_wr(8'h3C);
        host_model_i.start(1'h0, 8'hC3);
        tick(4);
        host_model_i.stop();
        tick(6);
        check({7'h00, ctl_pin_oe_o[2]}, 8'h00, "request withheld when full");
        wr_ready_i <= 1'h1;
        wait_wr(8'hC3);
        tick(4);
        check({7'h00, wr_valid_o}, 8'h00, "buffer drained");
        check({6'h00, ctl_pin_oe_o[2], pin_lvl[2]}, 8'h02, "request pulled low");
        $display("test write done");
    endtask
    task test_ack();
        for (int m = 1; m >= 0; m--)
        begin
            ack_dma_mode_i <= m[0];
            host_model_i.set_ack(1'h0);
            tick(3);
            check({7'h00, host_data_lines_oe_o}, 8'h01, "ack drives lines");
            check(data_lvl, 8'h5A, "ack word");
            check({6'h00, dma_ack_o, int_ack_o}, m[0] ? 8'h02 : 8'h01, "ack role");
            tick(1);
            check({6'h00, dma_ack_o, int_ack_o}, 8'h00, "ack pulse one cycle");
            host_model_i.set_ack(1'h1);
            tick(4);
            check({7'h00, host_data_lines_oe_o}, 8'h00, "lines released after ack");
        end
        $display("test ack done");
    endtask
    task test_gpio();
        host_port_sel_i <= 1'h0;
        svc_req_i <= 1'h0;
        host_model_i.drive_pins(4'hF, 4'h5);
        tick(3);
        check({4'h0, gpio_in_o}, 8'h05, "lines read as inputs");
        host_model_i.drive_pins(4'h0, 4'h0);
        gpio_dir_i <= 4'hF;
        gpio_out_i <= 4'h4;
        tick(2);
        check({ctl_pin_oe_o, ctl_pin_o}, 8'hF4, "lines driven as outputs");
        check({4'h0, pin_lvl}, 8'h04, "line 13 drives high");
        $display("test gpio done");
    endtask

    initial
    begin
        test_reset();
        test_read();
        test_write();
        test_ack();
        test_gpio();
        close_out();
    end
endmodule
